// ==== core/ire_defs.svh ====
// Constants of the SIR pulse encoder/decoder: clock rates, pulse timing,
// control byte layout and reset values. Definitions only.
`ifndef IRE_DEFS_SVH
`define IRE_DEFS_SVH

// System clock and pulse reference.
`define IRE_SYS_CLK_HZ      25000000
`define IRE_REF_HZ          3686400

// Fixed narrow transmit pulse, least time rounded up to reference ticks.
`define IRE_NARROW_PULSE_NS 1627
`define IRE_NARROW_TICKS    ((64'd1627 * 64'd3686400 + 64'd999999999) / 64'd1000000000)

// Wide transmit pulse as a fraction of the bit time.
`define IRE_WIDE_NUM        14'h3
`define IRE_WIDE_SHIFT      4

// Control byte field positions.
`define IRE_CFG_RATE_LSB    0
`define IRE_CFG_RATE_MSB    3
`define IRE_CFG_WIDTH_BIT   4
`define IRE_CFG_USER_A_BIT  5
`define IRE_CFG_USER_B_BIT  6

// Reset values and rate code limits.
`define IRE_RATE_RST        4'h6
`define IRE_RATE_MAX        4'hc
`define IRE_NARROW_RST      1'b1
`define IRE_USER_RST        1'b0
`define IRE_CFG_LAST_BIT    3'h7

`endif

// ==== core/ire_pkg.sv ====
// Types shared by the SIR pulse encoder/decoder.
// Assumes ire_defs.svh supplies the numeric constants.
package ire_pkg;

    typedef logic [3:0]  ire_rate_t;
    typedef logic [11:0] ire_ticks_t;

    typedef enum logic [1:0] {
        PROG_IDLE,
        PROG_START,
        PROG_DATA,
        PROG_STOP
    } ire_prog_e;

endpackage : ire_pkg

// ==== core/ire_ref_tick.sv ====
// Fractional divider making a one-cycle enable at the pulse reference rate.
// Assumes one system clock and a reference rate below half the clock rate.
`timescale 1ns/100ps
`include "ire_defs.svh"
module ire_ref_tick #(
    parameter int SYS_HZ = `IRE_SYS_CLK_HZ,
    parameter int REF_HZ = `IRE_REF_HZ
) (
    // Clock and reset.
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    // Reference enable.
    output logic      ref_tick_out
);
    logic [31:0] acc_reg;
    logic [31:0] acc_next;
    logic [31:0] sum;
    logic        tick_next;

    // Every pulse and bit time counts this enable, so scaling the reference
    // scales every selectable rate alike.
    always_comb begin
        sum       = acc_reg + 32'(REF_HZ);
        tick_next = 1'b0;
        acc_next  = sum;
        if (sum >= 32'(SYS_HZ)) begin
            acc_next  = sum - 32'(SYS_HZ);
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_reg      <= 32'h0;
            ref_tick_out <= 1'b0;
        end else begin
            acc_reg      <= acc_next;
            ref_tick_out <= tick_next;
        end
    end

    AST_REF_SPACING: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ref_tick_out |=> !ref_tick_out)
        else $error("reference enable came on two cycles in a row");

endmodule : ire_ref_tick

// ==== core/ire_sir_endec.sv ====
// SIR encoder/decoder between a host serial line and an infrared transceiver.
// Assumes all inputs are synchronous to sys_clk_in.
// How it works
// - After power-on the rate is 9600 bit/s with no programming needed.
// - The reset input restores that same default state.
// - A high program select stops encoding and reads the host line as config.
// - The config word is a zero start bit then 8 data bits, LSB first.
// - A new rate takes effect only when program select falls again.
// - Config bits 0 to 3 pick one of thirteen rates from 115.2k to 1.2k.
// - Config bit 4 picks a fixed 1.627 us pulse or a 3/16 bit pulse.
// - Config bits 5 and 6 drive two user outputs and bit 7 is ignored.
// - In data mode every zero host bit, start bit included, makes one pulse.
// - Each pulse is cut to 3/16 of the bit or to 1.627 us as selected.
// - Each received pulse becomes a zero lasting one whole bit on the host.
// - Two lamp outputs follow the encoded transmit and decoded receive data.
// - All timing comes from a 3.6864 MHz reference enable.
// - The stretched output does not depend on the received pulse width.
`timescale 1ns/100ps
`include "ire_defs.svh"
module ire_sir_endec (
    // Clock and reset.
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    // Host serial side.
    input  wire logic rate_program_select_in,
    input  wire logic host_tx_serial_in,
    output logic      host_rx_serial_out,
    // Transceiver side.
    input  wire logic ir_rx_pulse_n_in,
    output logic      ir_tx_pulse_out,
    // Indicators and user outputs.
    output logic      tx_activity_lamp_out,
    output logic      rx_activity_lamp_out,
    output logic      pulse_width_select_out,
    output logic      user_output_a_out,
    output logic      user_output_b_out
);
    import ire_pkg::*;

    // Reference ticks per bit for each rate code.
    function automatic ire_ticks_t bit_ticks(input ire_rate_t code);
        unique case (code)
            4'h0:    bit_ticks = 12'h020;
            4'h1:    bit_ticks = 12'h040;
            4'h2:    bit_ticks = 12'h060;
            4'h3:    bit_ticks = 12'h0c0;
            4'h4:    bit_ticks = 12'h100;
            4'h5:    bit_ticks = 12'h120;
            4'h6:    bit_ticks = 12'h180;
            4'h7:    bit_ticks = 12'h200;
            4'h8:    bit_ticks = 12'h300;
            4'h9:    bit_ticks = 12'h400;
            4'ha:    bit_ticks = 12'h600;
            4'hb:    bit_ticks = 12'h800;
            default: bit_ticks = 12'hc00;
        endcase
    endfunction : bit_ticks

    logic       ref_tick;
    ire_ticks_t bit_len;
    ire_ticks_t pulse_len;
    logic [13:0] wide_len;
    logic       data_mode;

    ire_ref_tick u_ref_tick (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .ref_tick_out (ref_tick)
    );

    // Configuration state.
    ire_rate_t  rate_reg,      rate_next;
    ire_rate_t  pend_rate_reg, pend_rate_next;
    logic       narrow_reg,    narrow_next;
    logic       user_a_reg,    user_a_next;
    logic       user_b_reg,    user_b_next;
    logic       sel_d_reg;
    ire_prog_e  prog_st_reg,   prog_st_next;
    ire_ticks_t prog_cnt_reg,  prog_cnt_next;
    logic [2:0] prog_bit_reg,  prog_bit_next;
    logic [7:0] prog_sh_reg,   prog_sh_next;

    assign data_mode = !rate_program_select_in;
    assign bit_len   = bit_ticks(rate_reg);
    assign wide_len  = ({2'b00, bit_len} * `IRE_WIDE_NUM) >> `IRE_WIDE_SHIFT;
    assign pulse_len = narrow_reg ? 12'(`IRE_NARROW_TICKS) : wide_len[11:0];

    // The start bit is checked at its middle, later bits a whole bit apart,
    // so the 8N1 character is sampled at the centre of each bit.
    always_comb begin
        rate_next      = rate_reg;
        pend_rate_next = pend_rate_reg;
        narrow_next    = narrow_reg;
        user_a_next    = user_a_reg;
        user_b_next    = user_b_reg;
        prog_st_next   = prog_st_reg;
        prog_cnt_next  = prog_cnt_reg;
        prog_bit_next  = prog_bit_reg;
        prog_sh_next   = prog_sh_reg;
        if (sel_d_reg && data_mode) begin
            rate_next = pend_rate_reg;
        end
        if (data_mode) begin
            prog_st_next = PROG_IDLE;
        end else begin
            unique case (prog_st_reg)
                PROG_IDLE: begin
                    if (!host_tx_serial_in) begin
                        prog_st_next  = PROG_START;
                        prog_cnt_next = 12'h000;
                    end
                end
                PROG_START: begin
                    if (ref_tick) begin
                        prog_cnt_next = prog_cnt_reg + 12'h001;
                        if (prog_cnt_reg == (bit_len >> 1) - 12'h001) begin
                            prog_cnt_next = 12'h000;
                            prog_bit_next = 3'h0;
                            prog_st_next  = host_tx_serial_in ? PROG_IDLE : PROG_DATA;
                        end
                    end
                end
                PROG_DATA: begin
                    if (ref_tick) begin
                        prog_cnt_next = prog_cnt_reg + 12'h001;
                        if (prog_cnt_reg == bit_len - 12'h001) begin
                            prog_cnt_next = 12'h000;
                            prog_sh_next  = {host_tx_serial_in, prog_sh_reg[7:1]};
                            prog_bit_next = prog_bit_reg + 3'h1;
                            if (prog_bit_reg == `IRE_CFG_LAST_BIT) begin
                                prog_st_next = PROG_STOP;
                            end
                        end
                    end
                end
                PROG_STOP: begin
                    if (ref_tick) begin
                        prog_cnt_next = prog_cnt_reg + 12'h001;
                        if (prog_cnt_reg == bit_len - 12'h001) begin
                            prog_st_next = PROG_IDLE;
                            // A character without its stop bit is dropped whole.
                            if (host_tx_serial_in) begin
                                if (prog_sh_reg[`IRE_CFG_RATE_MSB:`IRE_CFG_RATE_LSB]
                                        <= `IRE_RATE_MAX) begin
                                    pend_rate_next =
                                        prog_sh_reg[`IRE_CFG_RATE_MSB:`IRE_CFG_RATE_LSB];
                                end
                                narrow_next = prog_sh_reg[`IRE_CFG_WIDTH_BIT];
                                user_a_next = prog_sh_reg[`IRE_CFG_USER_A_BIT];
                                user_b_next = prog_sh_reg[`IRE_CFG_USER_B_BIT];
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rate_reg               <= `IRE_RATE_RST;
            pend_rate_reg          <= `IRE_RATE_RST;
            narrow_reg             <= `IRE_NARROW_RST;
            user_a_reg             <= `IRE_USER_RST;
            user_b_reg             <= `IRE_USER_RST;
            sel_d_reg              <= 1'b0;
            prog_st_reg            <= PROG_IDLE;
            prog_cnt_reg           <= 12'h000;
            prog_bit_reg           <= 3'h0;
            prog_sh_reg            <= 8'h00;
            pulse_width_select_out <= `IRE_NARROW_RST;
            user_output_a_out      <= `IRE_USER_RST;
            user_output_b_out      <= `IRE_USER_RST;
        end else begin
            rate_reg               <= rate_next;
            pend_rate_reg          <= pend_rate_next;
            narrow_reg             <= narrow_next;
            user_a_reg             <= user_a_next;
            user_b_reg             <= user_b_next;
            sel_d_reg              <= rate_program_select_in;
            prog_st_reg            <= prog_st_next;
            prog_cnt_reg           <= prog_cnt_next;
            prog_bit_reg           <= prog_bit_next;
            prog_sh_reg            <= prog_sh_next;
            pulse_width_select_out <= narrow_next;
            user_output_a_out      <= user_a_next;
            user_output_b_out      <= user_b_next;
        end
    end

    // Transmit encoder: one short pulse at the start of each low bit.
    logic       tx_busy_reg, tx_busy_next;
    ire_ticks_t tx_cnt_reg,  tx_cnt_next;
    logic       tx_pulse_next;

    always_comb begin
        tx_busy_next  = tx_busy_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_pulse_next = ir_tx_pulse_out;
        if (!data_mode) begin
            tx_busy_next  = 1'b0;
            tx_pulse_next = 1'b0;
        end else if (!tx_busy_reg) begin
            if (!host_tx_serial_in) begin
                tx_busy_next  = 1'b1;
                tx_cnt_next   = 12'h000;
                tx_pulse_next = 1'b1;
            end
        end else if (ref_tick) begin
            tx_cnt_next = tx_cnt_reg + 12'h001;
            // The first tick after an idle start is only part of a tick, so the
            // first bit runs one tick long; each bit end then samples the new bit.
            if (tx_cnt_next == pulse_len + 12'h001) begin
                tx_pulse_next = 1'b0;
            end
            if (tx_cnt_reg == bit_len) begin
                if (!host_tx_serial_in) begin
                    tx_cnt_next   = 12'h001;
                    tx_pulse_next = 1'b1;
                end else begin
                    tx_busy_next  = 1'b0;
                    tx_pulse_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_busy_reg          <= 1'b0;
            tx_cnt_reg           <= 12'h000;
            ir_tx_pulse_out      <= 1'b0;
            tx_activity_lamp_out <= 1'b0;
        end else begin
            tx_busy_reg          <= tx_busy_next;
            tx_cnt_reg           <= tx_cnt_next;
            ir_tx_pulse_out      <= tx_pulse_next;
            tx_activity_lamp_out <= tx_pulse_next;
        end
    end

    // Receive decoder: only the falling edge of a pulse is used, so its
    // width cannot change the stretched bit.
    logic       rx_prev_reg;
    logic       rx_busy_reg, rx_busy_next;
    ire_ticks_t rx_cnt_reg,  rx_cnt_next;
    logic       rx_out_next;

    always_comb begin
        rx_busy_next = rx_busy_reg;
        rx_cnt_next  = rx_cnt_reg;
        rx_out_next  = host_rx_serial_out;
        if (rx_prev_reg && !ir_rx_pulse_n_in) begin
            rx_busy_next = 1'b1;
            rx_cnt_next  = 12'h000;
            rx_out_next  = 1'b0;
        end else if (rx_busy_reg && ref_tick) begin
            rx_cnt_next = rx_cnt_reg + 12'h001;
            if (rx_cnt_reg == bit_len - 12'h001) begin
                rx_busy_next = 1'b0;
                rx_out_next  = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_prev_reg          <= 1'b1;
            rx_busy_reg          <= 1'b0;
            rx_cnt_reg           <= 12'h000;
            host_rx_serial_out   <= 1'b1;
            rx_activity_lamp_out <= 1'b0;
        end else begin
            rx_prev_reg          <= ir_rx_pulse_n_in;
            rx_busy_reg          <= rx_busy_next;
            rx_cnt_reg           <= rx_cnt_next;
            host_rx_serial_out   <= rx_out_next;
            rx_activity_lamp_out <= !rx_out_next;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_RESET_RATE: assert property (
        $rose(rst_n_in) |-> rate_reg == `IRE_RATE_RST && narrow_reg == `IRE_NARROW_RST)
        else $error("rate or pulse width not at default after reset");
    AST_PROG_SILENT: assert property (
        rate_program_select_in |=> !ir_tx_pulse_out)
        else $error("transmit pulse while programming");
    AST_RATE_ON_FALL: assert property (
        $changed(rate_reg) |-> $past(sel_d_reg) && !$past(rate_program_select_in))
        else $error("rate changed outside the program select fall");
    AST_RATE_LEGAL: assert property (
        rate_reg <= `IRE_RATE_MAX)
        else $error("illegal rate code became active");
    AST_USER_FROM_PROG: assert property (
        $changed(user_output_a_out) || $changed(user_output_b_out)
        |-> $past(prog_st_reg) == PROG_STOP)
        else $error("user output changed outside a programmed character");
    AST_DATA_BIT_COUNT: assert property (
        prog_st_reg == PROG_DATA ##1 prog_st_reg == PROG_STOP |-> prog_bit_reg == 3'h0)
        else $error("configuration character did not hold eight data bits");
    AST_TX_START: assert property (
        data_mode && !tx_busy_reg && !host_tx_serial_in |=> ir_tx_pulse_out && tx_busy_reg)
        else $error("low host bit produced no transmit pulse");
    AST_TX_WIDTH: assert property (
        $fell(ir_tx_pulse_out) && $past(data_mode) |-> tx_cnt_reg == pulse_len + 12'h001)
        else $error("transmit pulse width wrong");
    AST_RX_STRETCH: assert property (
        $rose(host_rx_serial_out) |-> $past(rx_cnt_reg) == bit_len - 12'h001)
        else $error("received bit not stretched to one bit time");
    AST_RX_LAMP: assert property (
        $fell(host_rx_serial_out) |-> rx_activity_lamp_out ##1 rx_activity_lamp_out)
        else $error("receive lamp does not follow decoded data");
    AST_RX_IDLE: assert property (
        !rx_busy_reg |-> host_rx_serial_out)
        else $error("host receive line low while idle");

    COV_RATE_CHANGE: cover property ($changed(rate_reg));
    COV_TX_PULSE:    cover property ($fell(ir_tx_pulse_out) && data_mode);
    COV_RX_STRETCH:  cover property ($rose(host_rx_serial_out));
    COV_USER_SET:    cover property ($rose(user_output_a_out));

endmodule : ire_sir_endec

// ==== dv/ire_partner.sv ====
// Far-side model: the host UART transmitter and the transceiver's receive output.
// Assumes clk_in is the bench clock; both lines change on its falling edge.
`timescale 1ns/100ps
module ire_partner (
    // Clock.
    input  wire logic clk_in,
    // Lines into the endec.
    output logic      host_tx_out,
    output logic      ir_rx_pulse_n_out
);
    initial begin
        host_tx_out       = 1'b1;
        ir_rx_pulse_n_out = 1'b1;
    end

    // Sends one 8N1 character, bit_clk clocks a bit, at the active rate.
    task automatic send_byte(input logic [7:0] b, input int bit_clk);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_in);
            host_tx_out = frame[i];
            repeat (bit_clk - 1) @(negedge clk_in);
        end
    endtask : send_byte

    // Drives one active-low receive pulse of w clocks.
    task automatic send_pulse(input int w);
        @(negedge clk_in);
        ir_rx_pulse_n_out = 1'b0;
        repeat (w) @(negedge clk_in);
        ir_rx_pulse_n_out = 1'b1;
    endtask : send_pulse
endmodule : ire_partner

// ==== dv/ire_sir_endec_bench.sv ====
// Self-checking bench of the SIR encoder/decoder against an integer model.
// Assumes ire_partner drives the host transmit and transceiver receive lines.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module ire_sir_endec_bench;
    import ire_pkg::*;
    logic sys_clk_in, rst_n_in, sel, host_tx, ir_rx_n, host_rx, ir_tx;
    logic tx_lamp, rx_lamp, width_sel, user_a, user_b;
    int fails, n_checks, cycles, pw;
    int widths[$];
    int bt[13] = '{32, 64, 96, 192, 256, 288, 384, 512, 768, 1024, 1536, 2048, 3072};
    int rate_m, pend_m, wid_m, ua_m, ub_m;
    logic [31:0] seed = 32'h2d5ba492;

    ire_sir_endec ire_sir_endec_i (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .rate_program_select_in(sel), .host_tx_serial_in(host_tx),
        .host_rx_serial_out(host_rx), .ir_rx_pulse_n_in(ir_rx_n),
        .ir_tx_pulse_out(ir_tx), .tx_activity_lamp_out(tx_lamp),
        .rx_activity_lamp_out(rx_lamp), .pulse_width_select_out(width_sel),
        .user_output_a_out(user_a), .user_output_b_out(user_b));
    ire_partner partner_i (.clk_in(sys_clk_in), .host_tx_out(host_tx),
        .ir_rx_pulse_n_out(ir_rx_n));

    always #20 sys_clk_in = ~sys_clk_in;

    // Pulse widths are gathered on every falling edge and the lamps compared on each one out of reset.
    always @(negedge sys_clk_in) begin
        if (ir_tx === 1'b1) begin
            pw++;
        end else if (pw > 0) begin
            widths.push_back(pw);
            pw = 0;
        end
        if (rst_n_in) begin
            `CHK(tx_lamp, ir_tx)
            `CHK(rx_lamp, ~host_rx)
        end
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 100000) begin
            fails++;
            end_of_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Clocks for a count of reference ticks.
    function automatic int clk_of(input int t);
        return int'(longint'(t) * 25000000 / 3686400);
    endfunction : clk_of

    // Passes the expected value through when the measurement is close enough.
    function automatic int near(input int m, input int e);
        return ((m - e) <= 10 && (e - m) <= 10) ? e : m;
    endfunction : near

    task automatic m_reset();
        rate_m = 6;
        pend_m = 6;
        wid_m = 1;
        ua_m = 0;
        ub_m = 0;
    endtask : m_reset

    task automatic chk_cfg();
        `CHK(width_sel, 1'(wid_m))
        `CHK(user_a, 1'(ua_m))
        `CHK(user_b, 1'(ub_m))
    endtask : chk_cfg

    task automatic prog(input logic [7:0] b);
        partner_i.send_byte(b, clk_of(bt[rate_m]));
        if (b[3:0] <= 4'hc) begin
            pend_m = b[3:0];
        end
        wid_m = b[4];
        ua_m = b[5];
        ub_m = b[6];
    endtask : prog

    task automatic set_sel(input logic v);
        @(negedge sys_clk_in);
        sel = v;
        if (!v) begin
            rate_m = pend_m;
        end
        repeat (4) @(negedge sys_clk_in);
    endtask : set_sel

    task automatic tx_byte();
        logic [7:0] b;
        int exp_w;
        b = 8'(rnd());
        widths.delete();
        partner_i.send_byte(b, clk_of(bt[rate_m]));
        exp_w = wid_m ? 6 : bt[rate_m] * 3 / 16;
        exp_w = clk_of(exp_w);
        `CHK(widths.size(), 9 - $countones(b))
        foreach (widths[i]) `CHK(near(widths[i], exp_w), exp_w)
    endtask : tx_byte

    task automatic rx_bit(input int w);
        int n;
        int exp_c;
        n = 0;
        exp_c = clk_of(bt[rate_m]);
        fork
            partner_i.send_pulse(w);
            begin
                for (int i = 0; i < 200 && host_rx !== 1'b0; i++) @(negedge sys_clk_in);
                while (host_rx === 1'b0 && n < 30000) begin
                    @(negedge sys_clk_in);
                    n++;
                end
            end
        join
        `CHK(near(n, exp_c), exp_c)
    endtask : rx_bit

    task automatic end_of_test();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    initial begin
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        sel = 1'b0;
        m_reset();
        repeat (20) @(negedge sys_clk_in);
        `CHK(host_rx, 1'b1)
        `CHK(ir_tx, 1'b0)
        chk_cfg();
        rst_n_in = 1'b1;
        rx_bit(12);
        rx_bit(10 + rnd() % 1000);
        set_sel(1'b1);
        widths.delete();
        prog(8'h30);
        chk_cfg();
        `CHK(widths.size(), 0)
        rx_bit(40);
        set_sel(1'b0);
        tx_byte();
        rx_bit(20);
        set_sel(1'b1);
        for (int c = 0; c <= 12; c++) prog(8'hd0 | c[7:0]);
        chk_cfg();
        prog(8'h41);
        for (int c = 13; c <= 15; c++) prog(8'h40 | c[7:0]);
        chk_cfg();
        set_sel(1'b0);
        rx_bit(10 + rnd() % 200);
        tx_byte();
        set_sel(1'b1);
        prog(8'h12);
        set_sel(1'b0);
        chk_cfg();
        rx_bit(15);
        @(negedge sys_clk_in);
        rst_n_in = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        m_reset();
        chk_cfg();
        rst_n_in = 1'b1;
        rx_bit(30);
        end_of_test();
    end
endmodule : ire_sir_endec_bench
